// ---- common/rcg_pkg.sv ----
// package for the ranging code generator: constants, tap table, states
// assumes a 100 MHz system clock; chip strobe derived from it
package rcg_pkg;

  localparam int          CLOCK_HZ       = 100_000_000;
  localparam int          CHIP_RATE_MHZ_X1000 = 1023;       // 1.023 MHz
  localparam int          STAGES         = 10;
  localparam int          CODE_LEN       = 1023;
  localparam int          BITS_PER_DATA  = 20;               // epochs per bit
  localparam logic [9:0]  INIT_STATE     = 10'h3_FF;
  localparam logic [5:0]  SIG_MAX_SPACE  = 6'h2_0;          // 32
  // phase accumulator increment for chip rate: 2^32 * f_chip / f_clk
  localparam longint      PHASE_INC_L    =
    (64'd4294967296 * CHIP_RATE_MHZ_X1000 * 1000) / CLOCK_HZ;
  localparam logic [31:0] PHASE_INC      = PHASE_INC_L[31:0];
  localparam int          FIFO_DEPTH     = 4;

  // generator states, gray along reset -> run
  typedef enum logic [1:0] {
    RCG_IDLE  = 2'b00,
    RCG_RUN   = 2'b01,
    RCG_FAULT = 2'b11
  } rcg_state_t;

  // stage pair per signal number, stages numbered 1..10, {a,b} in nibbles
  function automatic logic [7:0] rcg_taps(input logic [5:0] sig);
    case (sig)
      6'd1: rcg_taps = 8'h2_6;   6'd2: rcg_taps = 8'h3_7;
      6'd3: rcg_taps = 8'h4_8;   6'd4: rcg_taps = 8'h5_9;
      6'd5: rcg_taps = 8'h1_9;   6'd6: rcg_taps = 8'h2_A;
      6'd7: rcg_taps = 8'h1_8;   6'd8: rcg_taps = 8'h2_9;
      6'd9: rcg_taps = 8'h3_A;   6'd10: rcg_taps = 8'h2_3;
      6'd11: rcg_taps = 8'h3_4;  6'd12: rcg_taps = 8'h5_6;
      6'd13: rcg_taps = 8'h6_7;  6'd14: rcg_taps = 8'h7_8;
      6'd15: rcg_taps = 8'h8_9;  6'd16: rcg_taps = 8'h9_A;
      6'd17: rcg_taps = 8'h1_4;  6'd18: rcg_taps = 8'h2_5;
      6'd19: rcg_taps = 8'h3_6;  6'd20: rcg_taps = 8'h4_7;
      6'd21: rcg_taps = 8'h5_8;  6'd22: rcg_taps = 8'h6_9;
      6'd23: rcg_taps = 8'h1_3;  6'd24: rcg_taps = 8'h4_6;
      6'd25: rcg_taps = 8'h5_7;  6'd26: rcg_taps = 8'h6_8;
      6'd27: rcg_taps = 8'h7_9;  6'd28: rcg_taps = 8'h8_A;
      6'd29: rcg_taps = 8'h1_6;  6'd30: rcg_taps = 8'h2_7;
      6'd31: rcg_taps = 8'h3_8;  6'd32: rcg_taps = 8'h4_9;
      6'd33: rcg_taps = 8'h5_A;  6'd34: rcg_taps = 8'h4_A;
      6'd35: rcg_taps = 8'h1_7;  6'd36: rcg_taps = 8'h2_8;
      6'd37: rcg_taps = 8'h4_A;
      default: rcg_taps = 8'h0_0;
    endcase
  endfunction

endpackage

// ---- logic/rcg_fifo.sv ----
// small valid/ready fifo holding navigation data bits
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
module rcg_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 4
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [AW:0]      count, next_count;
  logic             push, pop;

  // honest full and empty from the occupancy count
  // count is one bit wider than the pointers, so full is compared at that width
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  // pointer and count next values
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // registers; storage needs no reset
  always_ff @(posedge clock) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule // rcg_fifo

// ---- logic/rcg_lfsr.sv ----
// one ten-stage fibonacci shift register with reload
// assumes step and reload are single-cycle strobes of the system clock
`timescale 1ns/1ps
module rcg_lfsr #(
  parameter logic [9:0] FEEDBACK = 10'h0_04   // stages 1..10 -> bits 0..9
) (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       step,
  input  wire logic       reload,
  output logic      [9:0] stages
);
  logic [9:0] next_stages;

  // stage 1 takes the xor of feedback taps; others shift toward stage 10
  always_comb begin
    next_stages = stages;
    if (reload) begin
      next_stages = rcg_pkg::INIT_STATE;
    end else if (step) begin
      next_stages = {stages[8:0], ^(stages & FEEDBACK)};
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      stages <= rcg_pkg::INIT_STATE;
    end else begin
      stages <= next_stages;
    end
  end

endmodule // rcg_lfsr

// ---- logic/rcg_top.sv ----
// ranging code generator: gold code xor buffered data bits
// assumes data bits arrive over valid/ready; sig select is held steady
`timescale 1ns/1ps
module rcg_top #(
  parameter int FIFO_DEPTH = rcg_pkg::FIFO_DEPTH
) (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic [5:0] signal_sel,
  input  wire logic       space_mode,
  input  wire logic       malfunction,
  input  wire logic       data_bit,
  input  wire logic       data_valid,
  output logic            data_ready,
  output logic            chip_out,
  output logic            chip_strobe,
  output logic            epoch,
  output logic            code_valid,
  output logic            data_underrun
);
  // polynomial feedback masks: stage 10 and 3; 10,9,8,6,3,2
  localparam logic [9:0] FB_FIRST  = 10'h2_04;
  localparam logic [9:0] FB_SECOND = 10'h3_A6;

  rcg_pkg::rcg_state_t state, next_state;

  logic [31:0] phase, next_phase;
  logic        tick;
  logic [9:0]  chip_cnt, next_chip_cnt;
  logic [4:0]  epoch_cnt, next_epoch_cnt;
  logic        last_chip, bit_end;
  logic [9:0]  first_lfsr_sequence_r, second_lfsr_sequence_r;
  logic        first_lfsr_sequence, delayed_second_sequence;
  logic [7:0]  taps;
  logic [3:0]  tap_a, tap_b;
  logic        sig_ok;
  logic        cur_bit, next_cur_bit;
  logic        fifo_bit, fifo_valid;
  logic        under, next_under;
  logic [9:0]  fault_substitute_code, next_fault_code;
  logic        next_chip_out, next_code_valid;
  logic        gold, next_epoch;

  // chip strobe from one phase accumulator keeps all timing coherent
  always_comb begin
    {tick, next_phase} =
      {1'b0, phase} + {1'b0, rcg_pkg::PHASE_INC};
    if (state != rcg_pkg::RCG_RUN && state != rcg_pkg::RCG_FAULT) begin
      tick       = 1'b0;
      next_phase = '0;
    end
  end

  // epoch at the 1023rd chip; data bit ends every twenty epochs
  assign last_chip = tick && (chip_cnt == 10'(rcg_pkg::CODE_LEN - 1));
  assign bit_end   = last_chip &&
                     (epoch_cnt == 5'(rcg_pkg::BITS_PER_DATA - 1));

  always_comb begin
    next_chip_cnt  = chip_cnt;
    next_epoch_cnt = epoch_cnt;
    if (last_chip) begin
      next_chip_cnt  = '0;
      next_epoch_cnt = bit_end ? '0 : epoch_cnt + 1'b1;
    end else if (tick) begin
      next_chip_cnt  = chip_cnt + 1'b1;
    end
  end

  // both generators step per chip and reload at the epoch
  rcg_lfsr #(
    .FEEDBACK (FB_FIRST)
  ) u_first (
    .clock  (clock),
    .srst   (srst),
    .step   (tick),
    .reload (last_chip),
    .stages (first_lfsr_sequence_r)
  );

  rcg_lfsr #(
    .FEEDBACK (FB_SECOND)
  ) u_second (
    .clock  (clock),
    .srst   (srst),
    .step   (tick),
    .reload (last_chip),
    .stages (second_lfsr_sequence_r)
  );

  // tap lookup; nibble 0 marks an unlisted signal number
  assign taps   = rcg_pkg::rcg_taps(signal_sel);
  assign tap_a  = taps[7:4];
  assign tap_b  = taps[3:0];
  assign sig_ok = (taps != 8'h0_0) &&
                  !(space_mode && signal_sel > rcg_pkg::SIG_MAX_SPACE);

  // output from stage ten; delayed copy from the two selected stages
  assign first_lfsr_sequence     = first_lfsr_sequence_r[9];
  assign delayed_second_sequence = sig_ok ?
    (second_lfsr_sequence_r[tap_a - 4'd1] ^
     second_lfsr_sequence_r[tap_b - 4'd1]) : 1'b0;
  assign gold = first_lfsr_sequence ^ delayed_second_sequence;

  // data bits buffered so the source may run ahead of the epoch
  rcg_fifo #(
    .WIDTH (1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .srst      (srst),
    .in_data   (data_bit),
    .in_valid  (data_valid),
    .in_ready  (data_ready),
    .out_data  (fifo_bit),
    .out_valid (fifo_valid),
    .out_ready (bit_end)
  );

  // new data bit taken only at a bit boundary; a missing bit holds old one
  always_comb begin
    next_cur_bit = cur_bit;
    next_under   = under;
    if (bit_end) begin
      next_under = !fifo_valid;
      if (fifo_valid) begin
        next_cur_bit = fifo_bit;
      end
    end
  end

  // substitute code: a free-running scrambler, deliberately not a gold code
  always_comb begin
    next_fault_code = fault_substitute_code;
    if (tick) begin
      next_fault_code = {fault_substitute_code[8:0],
                         fault_substitute_code[9] ^ fault_substitute_code[6]};
    end
  end

  // run state; a raised malfunction latches until reset
  always_comb begin
    case (state)
      // a malfunction in the first cycle after reset must latch as well
      rcg_pkg::RCG_IDLE:  next_state = malfunction ? rcg_pkg::RCG_FAULT
                                                   : rcg_pkg::RCG_RUN;
      rcg_pkg::RCG_RUN:   next_state = malfunction ? rcg_pkg::RCG_FAULT
                                                   : rcg_pkg::RCG_RUN;
      rcg_pkg::RCG_FAULT: next_state = rcg_pkg::RCG_FAULT;
      default:            next_state = rcg_pkg::RCG_IDLE;
    endcase
  end

  // composite chip, registered on each strobe
  always_comb begin
    next_chip_out   = chip_out;
    next_code_valid = code_valid;
    // mute wins over fault, so a blocked number never radiates anything
    if (tick) begin
      if (!sig_ok) begin
        next_chip_out   = 1'b0;
        next_code_valid = 1'b0;
      end else if (state == rcg_pkg::RCG_FAULT) begin
        next_chip_out   = fault_substitute_code[9];
        next_code_valid = 1'b0;
      end else begin
        next_chip_out   = gold ^ cur_bit;
        next_code_valid = 1'b1;
      end
    end
  end
  assign next_epoch = last_chip;

  always_ff @(posedge clock) begin
    if (srst) begin
      state                 <= rcg_pkg::RCG_IDLE;
      phase                 <= '0;
      chip_cnt              <= '0;
      epoch_cnt             <= '0;
      cur_bit               <= 1'b0;
      under                 <= 1'b0;
      fault_substitute_code <= rcg_pkg::INIT_STATE;
      chip_out              <= 1'b0;
      code_valid            <= 1'b0;
      chip_strobe           <= 1'b0;
      epoch                 <= 1'b0;
    end else begin
      state                 <= next_state;
      phase                 <= next_phase;
      chip_cnt              <= next_chip_cnt;
      epoch_cnt             <= next_epoch_cnt;
      cur_bit               <= next_cur_bit;
      under                 <= next_under;
      fault_substitute_code <= next_fault_code;
      chip_out              <= next_chip_out;
      code_valid            <= next_code_valid;
      chip_strobe           <= tick;
      epoch                 <= next_epoch;
    end
  end
  assign data_underrun = under;

endmodule // rcg_top

// ---- test/rcg_properties.sv ----
// port checker for the ranging code generator top
// assumes bind into rcg_top, one clock, srst synchronous active high
`timescale 1ns/1ps
module rcg_properties (
  input wire logic       clock,
  input wire logic       srst,
  input wire logic [5:0] signal_sel,
  input wire logic       space_mode,
  input wire logic       malfunction,
  input wire logic       chip_out,
  input wire logic       chip_strobe,
  input wire logic       epoch,
  input wire logic       code_valid
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  // chip timing: one-cycle strobe, 97 or 98 clocks apart
  property p_strobe_pulse;
    chip_strobe |=> !chip_strobe;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse)
    else $error("chip strobe wider than one cycle");
  property p_chip_rate;
    chip_strobe |-> ##[97:98] chip_strobe;
  endproperty
  a_chip_rate: assert property (p_chip_rate)
    else $error("chip spacing off the chip rate");
  property p_chip_hold;
    !chip_strobe |-> $stable(chip_out);
  endproperty
  a_chip_hold: assert property (p_chip_hold)
    else $error("chip output moved between strobes");
  property p_epoch_strobe;
    epoch |-> chip_strobe;
  endproperty
  a_epoch_strobe: assert property (p_epoch_strobe)
    else $error("epoch without chip strobe");
  // quiet right after reset, before the first chip
  property p_reset_quiet;
    $fell(srst) |-> !chip_strobe && !code_valid && !chip_out;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active right after reset");
  // muted selections give no code
  property p_space_mute;
    chip_strobe && space_mode && signal_sel >= 6'h21
      |-> !chip_out && !code_valid;
  endproperty
  a_space_mute: assert property (p_space_mute)
    else $error("reserved signal emitted in space mode");
  property p_sel_mute;
    chip_strobe && (signal_sel == 6'h00 || signal_sel > 6'h25)
      |-> !chip_out && !code_valid;
  endproperty
  a_sel_mute: assert property (p_sel_mute)
    else $error("unlisted signal number not muted");
  // a fault swaps the code within about one chip; valid then stays low for 8 cycles after it falls
  property p_fault_swap;
    malfunction |-> ##[1:120] !code_valid;
  endproperty
  a_fault_swap: assert property (p_fault_swap)
    else $error("standard code kept after malfunction");
  property p_fault_stays;
    $fell(code_valid) |=> !code_valid [*8];
  endproperty
  a_fault_stays: assert property (p_fault_stays)
    else $error("code valid came back without reset");
endmodule // rcg_properties

bind rcg_top rcg_properties u_props (
  .clock       (clock),
  .srst        (srst),
  .signal_sel  (signal_sel),
  .space_mode  (space_mode),
  .malfunction (malfunction),
  .chip_out    (chip_out),
  .chip_strobe (chip_strobe),
  .epoch       (epoch),
  .code_valid  (code_valid)
);

// ---- test/rcg_rx_model.sv ----
// receiver replica: regenerates the selected code and despreads it
// assumes chip_strobe marks each chip and reset starts a code period
`timescale 1ns/1ps
module rcg_rx_model (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic [7:0] tap_pair,
  input  wire logic       chip_out,
  input  wire logic       chip_strobe,
  output logic            despread
);
  logic [10:1] g1;
  logic [10:1] g2;
  // replica from current states, before they step on the strobe
  always_comb begin
    despread = chip_out ^ g1[10] ^ g2[tap_pair[7:4]]
             ^ g2[tap_pair[3:0]];
  end
  // own copies of both registers, in step with the received chips
  always @(posedge clock) begin
    if (srst) begin
      g1 <= 10'h3_FF;
      g2 <= 10'h3_FF;
    end else if (chip_strobe) begin
      g1 <= {g1[9:1], g1[3] ^ g1[10]};
      g2 <= {g2[9:1], g2[2] ^ g2[3] ^ g2[6] ^ g2[8] ^ g2[9] ^ g2[10]};
    end
  end
endmodule // rcg_rx_model

// ---- test/ranging_code_generator_tb.sv ----
// self-checking bench for rcg_top with a receiver replica beside it
// assumes a 100 MHz clock; inputs change on the falling edge
`timescale 1ns/1ps
module ranging_code_generator_tb;
  logic        clock, srst, space_mode, malfunction, data_bit, data_valid;
  logic [5:0]  signal_sel;
  logic        data_ready, chip_out, chip_strobe, epoch, code_valid;
  logic        data_underrun, despread;
  logic [7:0]  tap_pair;
  logic [10:1] g1, g2;
  int          n_mismatch, tests_run;
  localparam logic [7:0] TAPS [1:37] = '{8'h26, 8'h37, 8'h48, 8'h59,
    8'h19, 8'h2A, 8'h18, 8'h29, 8'h3A, 8'h23, 8'h34, 8'h56, 8'h67, 8'h78,
    8'h89, 8'h9A, 8'h14, 8'h25, 8'h36, 8'h47, 8'h58, 8'h69, 8'h13, 8'h46,
    8'h57, 8'h68, 8'h79, 8'h8A, 8'h16, 8'h27, 8'h38, 8'h49, 8'h5A, 8'h4A,
    8'h17, 8'h28, 8'h4A};

  assign tap_pair = (signal_sel inside {[1:37]}) ? TAPS[signal_sel] : 8'h12;

  rcg_top #(.FIFO_DEPTH(4)) DUT (.clock(clock), .srst(srst),
    .signal_sel(signal_sel), .space_mode(space_mode),
    .malfunction(malfunction), .data_bit(data_bit),
    .data_valid(data_valid), .data_ready(data_ready),
    .chip_out(chip_out), .chip_strobe(chip_strobe), .epoch(epoch),
    .code_valid(code_valid), .data_underrun(data_underrun));
  rcg_rx_model u_rx (.clock(clock), .srst(srst), .tap_pair(tap_pair),
    .chip_out(chip_out), .chip_strobe(chip_strobe), .despread(despread));

  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // bounded wait for the next chip strobe, sampled mid-cycle
  task automatic wait_strobe();
    int i;
    i = 0;
    @(negedge clock);
    while (chip_strobe !== 1'b1 && i < 200) begin
      @(negedge clock);
      i++;
    end
    if (i >= 200)
      check(10'h1, 10'h0);
  endtask

  // reset with a new selection; sel must not move while running
  task automatic restart(input logic [5:0] sel, input logic space);
    srst = 1'b1;
    signal_sel = sel;
    space_mode = space;
    repeat (2) @(negedge clock);
    srst = 1'b0;
    g1 = 10'h3_FF;
    g2 = 10'h3_FF;
  endtask

  // compare n chips with the bench model; data bit is 0 before a boundary
  task automatic run_chips(input int n, input logic good,
                           output logic [9:0] first);
    logic exp;
    first = 10'h0;
    for (int k = 0; k < n; k++) begin
      wait_strobe();
      exp = good & (g1[10] ^ g2[tap_pair[7:4]] ^ g2[tap_pair[3:0]]);
      check(10'(chip_out), 10'(exp));
      check(10'(code_valid), 10'(good));
      check(10'(epoch), 10'h0);
      check(10'(data_underrun), 10'h0);
      if (good)
        check(10'(despread), 10'h0);
      if (k < 10)
        first = {first[8:0], chip_out};
      g1 = {g1[9:1], g1[3] ^ g1[10]};
      g2 = {g2[9:1], g2[2] ^ g2[3] ^ g2[6] ^ g2[8] ^ g2[9] ^ g2[10]};
    end
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // watchdog: whole run needs about 42k cycles; give up at 90k
  initial begin
    #900_000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    logic [9:0] first;
    int acc;
    n_mismatch = 0;
    tests_run = 0;
    {srst, signal_sel, space_mode, malfunction} = {1'b1, 6'h01, 2'b00};
    {data_bit, data_valid} = 2'b00;
    void'($urandom(2086));
    repeat (12) @(negedge clock);
    srst = 1'b0;
    // nothing drains before a bit boundary, so four bits fill the buffer
    acc = 0;
    repeat (6) begin
      data_valid = 1'b1;
      data_bit = 1'($urandom());
      if (data_ready)
        acc++;
      @(negedge clock);
    end
    data_valid = 1'b0;
    check(10'(acc), 10'h4);
    check(10'(data_ready), 10'h0);
    // every selectable signal, eleven chips against the bench model; first ten against check values for 1, 34 and 37
    for (int s = 1; s <= 37; s++) begin
      restart(6'(s), 1'b0);
      run_chips(11, 1'b1, first);
      if (s == 1)
        check(first, 10'h3_20);
      if (s == 34 || s == 37)
        check(first, 10'h3_CB);
    end
    // space mode mutes the reserved numbers only
    for (int s = 32; s <= 37; s++) begin
      restart(6'(s), 1'b1);
      run_chips(2, s == 32, first);
    end
    restart(6'h00, 1'b0);
    run_chips(2, 1'b0, first);
    repeat (2) begin
      restart(6'(38 + $urandom_range(25)), 1'b0);
      run_chips(2, 1'b0, first);
    end
    // malfunction pulse mid-run: substitute code, flagged invalid
    restart(6'h05, 1'b0);
    run_chips(3, 1'b1, first);
    malfunction = 1'b1;
    @(negedge clock);
    malfunction = 1'b0;
    repeat (4) begin
      wait_strobe();
      check(10'(code_valid), 10'h0);
    end
    finish_test();
  end
endmodule // ranging_code_generator_tb
